// *** core/ppgseq_defs.svh ***
`ifndef PPGSEQ_DEFS_SVH
`define PPGSEQ_DEFS_SVH

// clock and conversion of nanoseconds to whole cycles, rounded up
`define PPGSEQ_CLK_HZ 20000000
`define PPGSEQ_CLK_MHZ 20
`define PPGSEQ_NS2CYC(ns) ((((ns) * `PPGSEQ_CLK_MHZ) + 999) / 1000)

// exposure integration times in ns
`define PPGSEQ_TINT0_NS 14800
`define PPGSEQ_TINT1_NS 29400
`define PPGSEQ_TINT2_NS 58700
`define PPGSEQ_TINT3_NS 117300

// led settling times in ns, select 0..3
`define PPGSEQ_SET0_NS 12000
`define PPGSEQ_SET1_NS 8000
`define PPGSEQ_SET2_NS 6000
`define PPGSEQ_SET3_NS 4000

// conversion rate: 8 sps shifted left by select, 9 gives 4096 sps
`define PPGSEQ_RATE_BASE_SPS 8
`define PPGSEQ_RATE_MAX_SEL 4'h9

// burst repeat rates in Hz
`define PPGSEQ_BURST0_HZ 8
`define PPGSEQ_BURST1_HZ 32
`define PPGSEQ_BURST2_HZ 84
`define PPGSEQ_BURST3_HZ 256

// slot codes and the index of the last slot
`define PPGSEQ_SLOT_NONE 4'h0
`define PPGSEQ_SLOT_AMB 4'hb
`define PPGSEQ_LAST_SLOT 3'h5

// trigger source code for external sample timing
`define PPGSEQ_GPIO_EXT 4'h2

// widths
`define PPGSEQ_ADC_W 20
`define PPGSEQ_ACC_W 28
`define PPGSEQ_CNT_W 24

`endif

// *** core/ppgseq_pkg.sv ***
package ppgseq_pkg;
  `include "ppgseq_defs.svh"

  // gray codes along idle-settle-integ-capt-next-push
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_settle = 3'h1,
    st_integ = 3'h3,
    st_capt = 3'h2,
    st_next = 3'h6,
    st_push_a = 3'h7,
    st_push_b = 3'h5
  } ppgseq_state_t;

  typedef struct packed {
    ppgseq_state_t state;
    logic [2:0] slot;
    logic pulse;
    logic [6:0] conv;
    logic [`PPGSEQ_CNT_W-1:0] cnt;
    logic [`PPGSEQ_CNT_W-1:0] rate_cnt;
    logic [`PPGSEQ_CNT_W-1:0] brst_cnt;
    logic grp_open;
    logic burst_clr;
    logic burst_on;
    logic contact;
    logic prox;
    logic busy;
    logic [2:0] gsync;
    logic [5:0][1:0][`PPGSEQ_ACC_W-1:0] acc;
    logic [5:0][1:0][`PPGSEQ_ADC_W-1:0] prev;
    logic [5:0] led;
    logic [2:0][7:0] dac;
    logic integ;
    logic amb_en;
    logic push;
    logic fpd;
    logic [`PPGSEQ_ADC_W-1:0] fdata;
    logic [2:0] fslot;
    logic [1:0] led_rng;
    logic [1:0] rng_a;
    logic [1:0] rng_b;
    logic [1:0] bias_a;
    logic [1:0] bias_b;
  } ppgseq_regs_t;
endpackage : ppgseq_pkg

// *** core/ppgseq_core.sv ***
`timescale 1ns/10ps
`include "ppgseq_defs.svh"

// Operation
// R01 - conversion rate selectable 8 to 4096 sps
// R02 - dual pulse: paired exposures averaged together
// R03 - four integration times, 14.8 to 117.3 us
// R04 - burst off: convert continuously at rate
// R05 - burst: average-count conversions per burst
// R06 - one averaged push per burst, four rates
// R07 - unfittable count falls to next fitting count
// R08 - rate too slow: burst self-clears
// R09 - four adc full-scale ranges per channel
// R10 - average 1 to 128 samples internally
// R11 - selectable photodiode bias settings
// R12 - slot picks single, paired or triple leds
// R13 - ambient slot unlit, none slot skipped
// R14 - slots one to six, every instance
// R15 - slots accept multiplexed leds four to six
// R16 - four led ranges, 8-bit current dac
// R17 - led settles 12/8/6/4 us first
// R18 - trigger option 2: external pin timing
// R19 - picket fence replaces wild ambient samples
// R20 - proximity mode saves energy without contact
// R21 - dual diode: one result per diode
// R22 - ambient cancel enabled during integration
// R23 - host drains results fast enough
module ppgseq_core #(
  parameter int unsigned RATE_BASE_CYC = `PPGSEQ_CLK_HZ / `PPGSEQ_RATE_BASE_SPS,
  parameter int unsigned BURST0_CYC = `PPGSEQ_CLK_HZ / `PPGSEQ_BURST0_HZ,
  parameter int unsigned BURST1_CYC = `PPGSEQ_CLK_HZ / `PPGSEQ_BURST1_HZ,
  parameter int unsigned BURST2_CYC = `PPGSEQ_CLK_HZ / `PPGSEQ_BURST2_HZ,
  parameter int unsigned BURST3_CYC = `PPGSEQ_CLK_HZ / `PPGSEQ_BURST3_HZ
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic enable_in,
  input wire logic [3:0] rate_sel_in,
  input wire logic [2:0] avg_sel_in,
  input wire logic dual_pulse_in,
  input wire logic [1:0] tint_sel_in,
  input wire logic [1:0] settle_sel_in,
  input wire logic burst_en_in,
  input wire logic [1:0] burst_rate_in,
  input wire logic amb_cancel_dis_in,
  input wire logic [1:0] adc_range_a_in,
  input wire logic [1:0] adc_range_b_in,
  input wire logic [1:0] pd_bias_a_in,
  input wire logic [1:0] pd_bias_b_in,
  input wire logic [1:0] led_range_in,
  input wire logic [7:0] led1_dac_in,
  input wire logic [7:0] led2_dac_in,
  input wire logic [7:0] led3_dac_in,
  input wire logic [3:0] gpio_ctrl_in,
  input wire logic gpio_trig_in,
  input wire logic pf_en_in,
  input wire logic [19:0] pf_thresh_in,
  input wire logic prox_en_in,
  input wire logic [19:0] prox_thresh_in,
  input wire logic dual_diode_in,
  input wire logic [3:0] sequence_slot_1_in,
  input wire logic [3:0] sequence_slot_2_in,
  input wire logic [3:0] sequence_slot_3_in,
  input wire logic [3:0] sequence_slot_4_in,
  input wire logic [3:0] sequence_slot_5_in,
  input wire logic [3:0] sequence_slot_6_in,
  input wire logic [19:0] adc_a_in,
  input wire logic [19:0] adc_b_in,
  output logic [5:0] led_on_out,
  output logic [23:0] led_dac_out,
  output logic [1:0] led_range_out,
  output logic integ_out,
  output logic amb_cancel_en_out,
  output logic [1:0] adc_range_a_out,
  output logic [1:0] adc_range_b_out,
  output logic [1:0] pd_bias_a_out,
  output logic [1:0] pd_bias_b_out,
  output logic fifo_push_out,
  output logic [19:0] fifo_data_out,
  output logic [2:0] fifo_slot_out,
  output logic fifo_pd_out,
  output logic burst_on_out,
  output logic prox_out,
  output logic busy_out
);

  ppgseq_pkg::ppgseq_regs_t st_r;
  ppgseq_pkg::ppgseq_regs_t st_nxt;

  logic [5:0][3:0] cfg;
  logic [2:0][7:0] dac_in;
  logic [3:0] rsel;
  logic [`PPGSEQ_CNT_W-1:0] rate_per;
  logic [`PPGSEQ_CNT_W-1:0] br_per;
  logic [`PPGSEQ_CNT_W-1:0] tint_cyc;
  logic [`PPGSEQ_CNT_W-1:0] set_cyc;
  logic too_slow;
  logic rate_tick;
  logic burst_tick;
  logic gpio_edge;
  logic ext_mode;
  logic start;
  logic pmode;
  logic [2:0] nsel;
  logic [7:0] grp_n;
  logic [6:0] grp_last;
  logic [3:0] sh;
  logic [1:0][19:0] raw;
  logic [1:0][19:0] pf_val;
  logic [1:0][19:0] avg_val;
  logic [3:0] code;

  // slot table in slot order
  assign cfg = {sequence_slot_6_in, sequence_slot_5_in, sequence_slot_4_in,
                sequence_slot_3_in, sequence_slot_2_in, sequence_slot_1_in};
  assign dac_in = {led3_dac_in, led2_dac_in, led1_dac_in};
  assign raw = {adc_b_in, adc_a_in};
  assign code = cfg[st_r.slot];

  // none and unused codes both skip, so a bad code costs no exposure
  function automatic logic is_skip(input logic [3:0] c);
    is_skip = (c == `PPGSEQ_SLOT_NONE) || (c > `PPGSEQ_SLOT_AMB);
  endfunction : is_skip

  // led set per slot code; ambient maps to no led
  function automatic logic [5:0] led_map(input logic [3:0] c);
    case (c)
      4'h1: led_map = 6'h01;
      4'h2: led_map = 6'h02;
      4'h3: led_map = 6'h04;
      4'h4: led_map = 6'h03;
      4'h5: led_map = 6'h05;
      4'h6: led_map = 6'h06;
      4'h7: led_map = 6'h07;
      4'h8: led_map = 6'h08;
      4'h9: led_map = 6'h10;
      4'ha: led_map = 6'h20;
      default: led_map = 6'h00;
    endcase
  endfunction : led_map

  // largest count not above the request whose burst fits the window
  function automatic logic [2:0] fit_sel(input logic [23:0] per, input logic [23:0] bper,
                                         input logic [2:0] want);
    logic [2:0] r;
    r = 3'h0;
    for (int k = 0; k < 8; k++) begin
      if ((3'(k) <= want) && (({7'h00, per} << k) <= {7'h00, bper})) begin
        r = 3'(k);
      end
    end
    fit_sel = r;
  endfunction : fit_sel

  // period and phase lengths from the selects
  always_comb begin
    rsel = (rate_sel_in > `PPGSEQ_RATE_MAX_SEL) ? `PPGSEQ_RATE_MAX_SEL : rate_sel_in;
    rate_per = `PPGSEQ_CNT_W'(RATE_BASE_CYC >> rsel); // R01
    case (burst_rate_in) // R06
      2'h0: br_per = `PPGSEQ_CNT_W'(BURST0_CYC);
      2'h1: br_per = `PPGSEQ_CNT_W'(BURST1_CYC);
      2'h2: br_per = `PPGSEQ_CNT_W'(BURST2_CYC);
      default: br_per = `PPGSEQ_CNT_W'(BURST3_CYC);
    endcase
    case (tint_sel_in) // R03
      2'h0: tint_cyc = `PPGSEQ_CNT_W'(`PPGSEQ_NS2CYC(`PPGSEQ_TINT0_NS));
      2'h1: tint_cyc = `PPGSEQ_CNT_W'(`PPGSEQ_NS2CYC(`PPGSEQ_TINT1_NS));
      2'h2: tint_cyc = `PPGSEQ_CNT_W'(`PPGSEQ_NS2CYC(`PPGSEQ_TINT2_NS));
      default: tint_cyc = `PPGSEQ_CNT_W'(`PPGSEQ_NS2CYC(`PPGSEQ_TINT3_NS));
    endcase
    case (settle_sel_in) // R17
      2'h0: set_cyc = `PPGSEQ_CNT_W'(`PPGSEQ_NS2CYC(`PPGSEQ_SET0_NS));
      2'h1: set_cyc = `PPGSEQ_CNT_W'(`PPGSEQ_NS2CYC(`PPGSEQ_SET1_NS));
      2'h2: set_cyc = `PPGSEQ_CNT_W'(`PPGSEQ_NS2CYC(`PPGSEQ_SET2_NS));
      default: set_cyc = `PPGSEQ_CNT_W'(`PPGSEQ_NS2CYC(`PPGSEQ_SET3_NS));
    endcase
  end

  // timing sources, group size and averaged results
  always_comb begin
    too_slow = rate_per > br_per; // R08
    rate_tick = st_r.rate_cnt == '0;
    burst_tick = st_r.brst_cnt == '0;
    gpio_edge = st_r.gsync[1] & ~st_r.gsync[2];
    ext_mode = gpio_ctrl_in == `PPGSEQ_GPIO_EXT;
    pmode = prox_en_in & ~st_r.contact; // R20
    nsel = st_r.burst_on ? fit_sel(rate_per, br_per, avg_sel_in) : avg_sel_in; // R07 R10
    grp_n = 8'h01 << nsel;
    grp_last = 7'(grp_n - 8'h01);
    sh = {1'b0, nsel} + {3'h0, dual_pulse_in}; // R02
    // a tick that lands while a sequence runs is dropped, not queued
    start = enable_in && (st_r.state == ppgseq_pkg::st_idle) &&
            (ext_mode ? gpio_edge : rate_tick) && // R18 R04
            (~st_r.burst_on | st_r.grp_open); // R05
    for (int i = 0; i < 2; i++) begin
      // one outlier is replaced; a real step recovers the next sample
      if (pf_en_in && (((raw[i] > st_r.prev[st_r.slot][i]) ?
          (raw[i] - st_r.prev[st_r.slot][i]) :
          (st_r.prev[st_r.slot][i] - raw[i])) > pf_thresh_in)) begin
        pf_val[i] = st_r.prev[st_r.slot][i]; // R19
      end else begin
        pf_val[i] = raw[i];
      end
      avg_val[i] = 20'(st_r.acc[st_r.slot][i] >> sh); // R10
    end
  end

  // next state of the whole block
  always_comb begin
    logic enter;
    logic adv;
    logic [3:0] ncode;
    enter = 1'b0;
    adv = 1'b0;
    ncode = 4'h0;
    st_nxt = st_r;
    st_nxt.gsync = {st_r.gsync[1:0], gpio_trig_in};
    st_nxt.push = 1'b0;
    st_nxt.burst_clr = burst_en_in & (st_r.burst_clr | too_slow); // R08
    st_nxt.burst_on = burst_en_in & ~st_nxt.burst_clr;
    st_nxt.rate_cnt = rate_tick ? (rate_per - 24'h1) : (st_r.rate_cnt - 24'h1);
    st_nxt.brst_cnt = (burst_tick | ~st_r.burst_on) ? (br_per - 24'h1) :
                      (st_r.brst_cnt - 24'h1);
    st_nxt.grp_open = st_r.burst_on & (st_r.grp_open | burst_tick); // R06
    case (st_r.state)
      ppgseq_pkg::st_idle: begin
        if (start) begin
          st_nxt.slot = 3'h0; // R14
          st_nxt.pulse = 1'b0;
          enter = 1'b1;
        end
      end
      ppgseq_pkg::st_settle: begin
        if (st_r.cnt == '0) begin
          st_nxt.state = ppgseq_pkg::st_integ;
          st_nxt.cnt = tint_cyc - 24'h1; // R03
        end else begin
          st_nxt.cnt = st_r.cnt - 24'h1;
        end
      end
      ppgseq_pkg::st_integ: begin
        if (st_r.cnt == '0) begin
          st_nxt.state = ppgseq_pkg::st_capt;
        end else begin
          st_nxt.cnt = st_r.cnt - 24'h1;
        end
      end
      ppgseq_pkg::st_capt: begin
        for (int i = 0; i < 2; i++) begin
          if (!pmode) begin
            st_nxt.acc[st_r.slot][i] = st_r.acc[st_r.slot][i] + `PPGSEQ_ACC_W'(pf_val[i]);
          end
          st_nxt.prev[st_r.slot][i] = raw[i];
        end
        if (prox_en_in && (st_r.slot == 3'h0)) begin
          st_nxt.contact = raw[0] >= prox_thresh_in; // R20
        end
        if (dual_pulse_in && !st_r.pulse) begin
          st_nxt.pulse = 1'b1; // R02
          enter = 1'b1;
        end else begin
          st_nxt.pulse = 1'b0;
          st_nxt.state = ppgseq_pkg::st_next;
        end
      end
      ppgseq_pkg::st_next: begin
        if (st_r.slot != `PPGSEQ_LAST_SLOT) begin
          st_nxt.slot = st_r.slot + 3'h1; // R14
          enter = 1'b1;
        end else if (!pmode && (st_r.conv >= grp_last)) begin
          st_nxt.state = ppgseq_pkg::st_push_a; // R06
          st_nxt.slot = 3'h0;
        end else begin
          st_nxt.state = ppgseq_pkg::st_idle;
          if (!pmode) begin
            st_nxt.conv = st_r.conv + 7'h01;
          end
        end
      end
      ppgseq_pkg::st_push_a: begin
        if (!is_skip(code)) begin
          st_nxt.push = 1'b1; // R12
          st_nxt.fdata = avg_val[0];
          st_nxt.fslot = st_r.slot;
          st_nxt.fpd = 1'b0;
        end
        if (!is_skip(code) && dual_diode_in) begin
          st_nxt.state = ppgseq_pkg::st_push_b; // R21
        end else begin
          adv = 1'b1;
        end
      end
      ppgseq_pkg::st_push_b: begin
        st_nxt.push = 1'b1; // R21
        st_nxt.fdata = avg_val[1];
        st_nxt.fslot = st_r.slot;
        st_nxt.fpd = 1'b1;
        adv = 1'b1;
      end
      default: begin
        st_nxt.state = ppgseq_pkg::st_idle;
      end
    endcase
    // walk the push over the slots, then start a fresh group
    if (adv) begin
      if (st_r.slot == `PPGSEQ_LAST_SLOT) begin
        st_nxt.state = ppgseq_pkg::st_idle;
        st_nxt.acc = '0;
        st_nxt.conv = 7'h00;
        st_nxt.grp_open = 1'b0;
      end else begin
        st_nxt.slot = st_r.slot + 3'h1;
        st_nxt.state = ppgseq_pkg::st_push_a;
      end
    end
    // open a slot: skip, ambient straight to integration, or settle first
    if (enter) begin
      ncode = cfg[st_nxt.slot];
      if (is_skip(ncode) || (pmode && (st_nxt.slot != 3'h0))) begin
        st_nxt.state = ppgseq_pkg::st_next; // R13 R20
      end else if (ncode == `PPGSEQ_SLOT_AMB) begin
        st_nxt.state = ppgseq_pkg::st_integ; // R13
        st_nxt.cnt = tint_cyc - 24'h1;
      end else begin
        st_nxt.state = ppgseq_pkg::st_settle; // R17
        st_nxt.cnt = set_cyc - 24'h1;
      end
    end
    if (!enable_in) begin
      st_nxt.state = ppgseq_pkg::st_idle;
      st_nxt.conv = 7'h00;
      st_nxt.acc = '0;
      st_nxt.grp_open = 1'b0;
    end
    // led drive follows the phase it is entering
    ncode = cfg[st_nxt.slot];
    st_nxt.led = ((st_nxt.state == ppgseq_pkg::st_settle) ||
                  (st_nxt.state == ppgseq_pkg::st_integ)) ? led_map(ncode) : 6'h00; // R12 R15
    for (int j = 0; j < 3; j++) begin
      // mux leds four to six share drivers one to three
      st_nxt.dac[j] = (st_nxt.led[j] | st_nxt.led[j+3]) ? dac_in[j] : 8'h00; // R16
    end
    st_nxt.integ = st_nxt.state == ppgseq_pkg::st_integ;
    st_nxt.amb_en = st_nxt.integ & ~amb_cancel_dis_in; // R22
    st_nxt.led_rng = led_range_in; // R16
    st_nxt.rng_a = adc_range_a_in; // R09
    st_nxt.rng_b = adc_range_b_in;
    st_nxt.bias_a = pd_bias_a_in; // R11
    st_nxt.bias_b = pd_bias_b_in;
    st_nxt.prox = prox_en_in & ~st_nxt.contact;
    st_nxt.busy = st_nxt.state != ppgseq_pkg::st_idle;
  end

  // single state register
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign led_on_out = st_r.led;
  assign led_dac_out = st_r.dac;
  assign led_range_out = st_r.led_rng;
  assign integ_out = st_r.integ;
  assign amb_cancel_en_out = st_r.amb_en;
  assign adc_range_a_out = st_r.rng_a;
  assign adc_range_b_out = st_r.rng_b;
  assign pd_bias_a_out = st_r.bias_a;
  assign pd_bias_b_out = st_r.bias_b;
  assign fifo_push_out = st_r.push;
  assign fifo_data_out = st_r.fdata;
  assign fifo_slot_out = st_r.fslot;
  assign fifo_pd_out = st_r.fpd;
  assign burst_on_out = st_r.burst_on;
  assign prox_out = st_r.prox;
  assign busy_out = st_r.busy;

  property p_rate;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      (rate_tick && $stable(rate_sel_in)) |=> (st_r.rate_cnt == $past(rate_per) - 24'h1);
  endproperty
  a_rate: assert property (p_rate) else $error("rate period reload wrong"); // R01

  property p_tint;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      $rose(integ_out) |-> ((st_r.cnt == $past(tint_cyc) - 24'h1) && $past(enable_in));
  endproperty
  a_tint: assert property (p_tint) else $error("integration length wrong"); // R03

  property p_settle;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      (st_r.state == ppgseq_pkg::st_settle && st_r.cnt == '0 && enable_in)
        |=> (integ_out && led_on_out != 6'h00);
  endproperty
  a_settle: assert property (p_settle) else $error("settle did not hand to integration"); // R17

  property p_skip;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      (st_r.state == ppgseq_pkg::st_settle) |-> (!is_skip(code) && code != `PPGSEQ_SLOT_AMB);
  endproperty
  a_skip: assert property (p_skip) else $error("skipped or ambient slot settled"); // R13

  property p_amb;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      (integ_out && code == `PPGSEQ_SLOT_AMB) |-> (led_on_out == 6'h00 && led_dac_out == '0);
  endproperty
  a_amb: assert property (p_amb) else $error("ambient slot lit an led"); // R13

  property p_order;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      (st_r.state == ppgseq_pkg::st_next && st_r.slot != `PPGSEQ_LAST_SLOT && enable_in)
        |=> (st_r.slot == $past(st_r.slot) + 3'h1);
  endproperty
  a_order: assert property (p_order) else $error("slot order broken"); // R14

  property p_gpio;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      (ext_mode && !gpio_edge && st_r.state == ppgseq_pkg::st_idle) |=> !busy_out;
  endproperty
  a_gpio: assert property (p_gpio) else $error("started without external trigger"); // R18

  property p_burst;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      (burst_en_in && too_slow) |=> (!burst_on_out ##1 (!burst_on_out || !burst_en_in));
  endproperty
  a_burst: assert property (p_burst) else $error("burst not cleared on slow rate"); // R08

  property p_dual;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      (st_r.state == ppgseq_pkg::st_push_b) |=> (fifo_push_out && fifo_pd_out);
  endproperty
  a_dual: assert property (p_dual) else $error("second diode result missing"); // R21

  property p_prox;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      (pmode && st_r.state == ppgseq_pkg::st_next) |=> (st_r.state != ppgseq_pkg::st_push_a);
  endproperty
  a_prox: assert property (p_prox) else $error("push during proximity mode"); // R20

endmodule : ppgseq_core

// *** testbench/ppgseq_host_model.sv ***
`timescale 1ns/10ps
module ppgseq_host_model (
  input wire logic sys_clk_in,
  input wire logic fifo_push_in,
  input wire logic [19:0] fifo_data_in,
  input wire logic [2:0] fifo_slot_in,
  input wire logic fifo_photodiode_input_pin
);
  logic [19:0] data_q[$];
  logic [2:0] slot_q[$];
  logic pd_q[$];
  int time_q[$];
  int cycle_r = 0;
  // drains every result in the cycle it stands, so nothing is overwritten
  always @(posedge sys_clk_in) begin
    cycle_r <= cycle_r + 1;
    if (fifo_push_in === 1'b1) begin
      data_q.push_back(fifo_data_in);
      slot_q.push_back(fifo_slot_in);
      pd_q.push_back(fifo_photodiode_input_pin);
      time_q.push_back(cycle_r);
    end
  end
endmodule : ppgseq_host_model

// *** testbench/ppgseq_core_tb.sv ***
`timescale 1ns/10ps
module ppgseq_core_tb;
  logic sys_clk_in = 1'b0;
  logic rst_b_in, enable_in, dual_pulse_in, burst_en_in, amb_cancel_dis_in, gpio_trig_in;
  logic pf_en_in, prox_en_in, dual_diode_in, trig_run, integ_d;
  logic [3:0] rate_sel_in, gpio_ctrl_in;
  logic [2:0] avg_sel_in, fifo_slot_out;
  logic [1:0] tint_sel_in, settle_sel_in, burst_rate_in, led_range_in, led_range_out;
  logic [1:0] adc_range_a_in, adc_range_b_in, pd_bias_a_in, pd_bias_b_in;
  logic [1:0] adc_range_a_out, adc_range_b_out, pd_bias_a_out, pd_bias_b_out;
  logic [7:0] led1_dac_in, led2_dac_in, led3_dac_in;
  logic [19:0] pf_thresh_in, prox_thresh_in, adc_a_in, adc_b_in, fifo_data_out;
  logic [3:0] slots [6];
  logic [5:0] led_on_out;
  logic [23:0] led_dac_out;
  logic integ_out, amb_cancel_en_out, fifo_push_out, fifo_pd_out, burst_on_out, prox_out;
  logic busy_out;
  int errors = 0, checks_done = 0, cycles = 0, rises = 0, n, k;
  int set_cyc [4] = '{240, 160, 120, 80};
  int tint_cyc [4] = '{296, 588, 1174, 2346};
  logic [5:0] pat [11] = '{6'h01, 6'h02, 6'h04, 6'h03, 6'h05, 6'h06, 6'h07, 6'h08, 6'h10,
                           6'h20, 6'h00};

  // short counts keep the run brief
  ppgseq_core #(.RATE_BASE_CYC(4096), .BURST0_CYC(8192), .BURST1_CYC(4096),
                .BURST2_CYC(2048), .BURST3_CYC(1024)) ppgseq_core_inst (
    .*, .sequence_slot_1_in(slots[0]), .sequence_slot_2_in(slots[1]),
    .sequence_slot_3_in(slots[2]), .sequence_slot_4_in(slots[3]),
    .sequence_slot_5_in(slots[4]), .sequence_slot_6_in(slots[5]));

  ppgseq_host_model ppgseq_host_model_inst (.sys_clk_in(sys_clk_in),
    .fifo_push_in(fifo_push_out), .fifo_data_in(fifo_data_out),
    .fifo_slot_in(fifo_slot_out), .fifo_photodiode_input_pin(fifo_pd_out));

  // clock
  always #25 sys_clk_in = ~sys_clk_in;
  // trigger pin toggles only inside a frame and rests low between frames
  always #200 gpio_trig_in <= trig_run ? ~gpio_trig_in : 1'b0;
  // cycle ceiling and count of integration starts
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    integ_d <= integ_out;
    if (integ_out === 1'b1 && integ_d === 1'b0) rises <= rises + 1;
    if (cycles == 90000) begin
      errors++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  function automatic logic cond(input int w);
    case (w)
      0: return busy_out === 1'b0;
      1: return led_on_out !== 6'h00;
      2: return integ_out === 1'b1;
      default: return integ_out === 1'b0;
    endcase
  endfunction : cond

  // counts falling edges until the condition holds, bounded
  task automatic span(input int w, output int c);
    c = 0;
    while (!cond(w) && c < 9000) begin
      @(negedge sys_clk_in);
      c++;
    end
  endtask : span

  task automatic wait_for(input int w);
    int c;
    span(w, c);
    if (c == 9000) chk("wait", w, 32'hffff);
  endtask : wait_for

  // idle plus two edges, so a push launched with the last state is counted
  task automatic quiet();
    wait_for(0);
    repeat (2) @(negedge sys_clk_in);
  endtask : quiet

  task automatic wait_push(input int want);
    int c;
    c = 0;
    while (ppgseq_host_model_inst.data_q.size() < want && c < 20000) begin
      @(negedge sys_clk_in);
      c++;
    end
    if (c == 20000) chk("push_wait", 0, 1);
  endtask : wait_push

  task automatic complete_run();
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  initial begin
    {rst_b_in, enable_in, dual_pulse_in, burst_en_in, amb_cancel_dis_in, gpio_trig_in} = '0;
    {pf_en_in, prox_en_in, dual_diode_in, trig_run, gpio_ctrl_in, avg_sel_in} = '0;
    {burst_rate_in, led_range_in, adc_range_a_in, adc_range_b_in} = '0;
    {pd_bias_a_in, pd_bias_b_in, pf_thresh_in, prox_thresh_in} = '0;
    rate_sel_in = 4'h3;
    tint_sel_in = 2'h0;
    settle_sel_in = 2'h3;
    {led1_dac_in, led2_dac_in, led3_dac_in} = 24'h3c2b1a;
    adc_a_in = 20'h12345;
    adc_b_in = 20'h0abcd;
    slots = '{4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
    repeat (6) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    enable_in = 1'b1;
    // settle and integration spans, ranges and cancel gating per select
    for (int i = 0; i < 4; i++) begin
      @(negedge sys_clk_in);
      {settle_sel_in, tint_sel_in, led_range_in, pd_bias_a_in} = {4{2'(i)}};
      {adc_range_a_in, adc_range_b_in, pd_bias_b_in} = {3{2'(3 - i)}};
      amb_cancel_dis_in = i[0];
      wait_for(0);
      wait_for(1);
      chk("led_on", led_on_out, 6'h01);
      chk("led_dac", led_dac_out, 24'h00003c);
      span(2, n);
      chk("settle", n, set_cyc[i]);
      chk("amb_cancel", amb_cancel_en_out, !i[0]);
      span(3, n);
      chk("integ", n, tint_cyc[i]);
      chk("ranges", {led_range_out, adc_range_a_out, adc_range_b_out, pd_bias_a_out,
          pd_bias_b_out}, {2'(i), 2'(3 - i), 2'(3 - i), 2'(i), 2'(3 - i)});
    end
    @(negedge sys_clk_in);
    {settle_sel_in, tint_sel_in, amb_cancel_dis_in} = 5'h08;
    // every lit and ambient slot code, changed only while idle
    for (int c = 1; c < 12; c++) begin
      wait_for(0);
      slots[0] = 4'(c);
      wait_for(2);
      chk("led_pattern", led_on_out, pat[c - 1]);
    end
    // slot order, skipped slot and one result per diode
    wait_for(0);
    slots = '{4'h1, 4'h2, 4'h3, 4'hb, 4'h0, 4'h4};
    dual_diode_in = 1'b1;
    quiet();
    k = ppgseq_host_model_inst.data_q.size();
    wait_push(k + 10);
    for (int j = 0; j < 10; j++) begin
      chk("slot_order", ppgseq_host_model_inst.slot_q[k + j], (j < 8) ? j / 2 : 5);
      chk("diode", ppgseq_host_model_inst.pd_q[k + j], j % 2);
      chk("diode_data", ppgseq_host_model_inst.data_q[k + j],
          j[0] ? 20'h0abcd : 20'h12345);
    end
    // four-sample average, then with paired exposures
    @(negedge sys_clk_in);
    dual_diode_in = 1'b0;
    slots = '{4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
    avg_sel_in = 3'h2;
    for (int dp = 0; dp < 2; dp++) begin
      @(negedge sys_clk_in);
      dual_pulse_in = dp[0];
      enable_in = 1'b0;
      @(negedge sys_clk_in);
      enable_in = 1'b1;
      n = rises;
      k = ppgseq_host_model_inst.data_q.size();
      wait_push(k + 1);
      chk("exposures", rises - n, 4 << dp);
      chk("avg_data", ppgseq_host_model_inst.data_q[k], 20'h12345);
    end
    // one outlier is replaced, a lasting step comes through; continuous spacing
    @(negedge sys_clk_in);
    {avg_sel_in, dual_pulse_in, pf_en_in} = 5'h01;
    pf_thresh_in = 20'h00100;
    quiet();
    k = ppgseq_host_model_inst.data_q.size();
    wait_push(k + 1);
    adc_a_in = 20'h40000;
    wait_push(k + 3);
    chk("fence_hold", ppgseq_host_model_inst.data_q[k + 1], 20'h12345);
    chk("fence_step", ppgseq_host_model_inst.data_q[k + 2], 20'h40000);
    chk("rate_period", ppgseq_host_model_inst.time_q[k + 2]
        - ppgseq_host_model_inst.time_q[k + 1], 512);
    // burst that fits, then a rate too slow for the burst rate
    @(negedge sys_clk_in);
    pf_en_in = 1'b0;
    adc_a_in = 20'h12345;
    burst_en_in = 1'b1;
    quiet();
    k = ppgseq_host_model_inst.data_q.size();
    wait_push(k + 2);
    chk("burst_on", burst_on_out, 1'b1);
    chk("burst_period", ppgseq_host_model_inst.time_q[k + 1]
        - ppgseq_host_model_inst.time_q[k], 8192);
    @(negedge sys_clk_in);
    rate_sel_in = 4'h0;
    burst_rate_in = 2'h3;
    repeat (20) @(negedge sys_clk_in);
    chk("burst_cleared", burst_on_out, 1'b0);
    burst_en_in = 1'b0;
    rate_sel_in = 4'h3;
    // external trigger: no internal ticks, a frame on the pin starts one
    gpio_ctrl_in = 4'h2;
    quiet();
    n = rises;
    repeat (1500) @(negedge sys_clk_in);
    chk("no_internal_tick", rises - n, 0);
    trig_run = 1'b1;
    repeat (40) @(negedge sys_clk_in);
    trig_run = 1'b0;
    span(2, n);
    chk("ext_trigger", n < 600, 1'b1);
    // proximity without contact: flagged and silent
    @(negedge sys_clk_in);
    gpio_ctrl_in = 4'h0;
    prox_en_in = 1'b1;
    prox_thresh_in = 20'hfffff;
    repeat (1500) @(negedge sys_clk_in);
    k = ppgseq_host_model_inst.data_q.size();
    repeat (1100) @(negedge sys_clk_in);
    chk("prox_mode", prox_out, 1'b1);
    chk("prox_silent", ppgseq_host_model_inst.data_q.size(), k);
    complete_run();
  end
endmodule : ppgseq_core_tb
